// ---- core/mco_pkg.sv ----
package mco_pkg;

	// Register bit positions inside the mode option configuration word
	localparam int unsigned CFG_W          = 16;
	localparam int unsigned BIT_BUS_SEL    = 9;
	localparam int unsigned BIT_SYNC_HI    = 8;
	localparam int unsigned BIT_SYNC_LO    = 7;
	localparam int unsigned BIT_VEC_OPT    = 6;
	localparam logic [15:0] CFG_RESET      = 16'h0000;

	// Status word service-request position
	localparam int unsigned STS_W          = 16;
	localparam int unsigned BIT_SRQ        = 8;

	// Sync option encodings
	localparam logic [1:0]  SYNC_HOST      = 2'h0;
	localparam logic [1:0]  SYNC_IF_EVEN   = 2'h1;
	localparam logic [1:0]  SYNC_IF_ODD    = 2'h2;
	localparam logic [1:0]  SYNC_ALWAYS    = 2'h3;

	// Command codes as seen by this block
	typedef enum logic [2:0]
	{
		MCO_CMD_NONE     = 3'h0,
		MCO_CMD_SYNC     = 3'h1,
		MCO_CMD_VECTOR   = 3'h2,
		MCO_CMD_SHUTDOWN = 3'h3,
		MCO_CMD_OVERRIDE = 3'h4
	} mco_cmd_t;

	// One decoded, validated mode command with its data
	typedef struct packed
	{
		mco_cmd_t    cmd;
		logic        broadcast;
		logic [15:0] data;
		logic        bus_match;
	} mco_req_t;

	// Handler FSM, Gray along idle -> act -> status
	typedef enum logic [1:0]
	{
		MCO_IDLE   = 2'b00,
		MCO_ACT    = 2'b01,
		MCO_STATUS = 2'b11
	} mco_state_t;

endpackage

// ---- core/mco_sync_decide.sv ----
`timescale 1ns/1ns
module mco_sync_decide
	import mco_pkg::*;
(
	// Option and data
	input  wire logic [1:0] i_opt,
	input  wire logic       i_bit0,
	// Decision
	output logic            o_load
);

	// Load decision per option setting
	assign o_load = (i_opt == SYNC_ALWAYS)
		| ((i_opt == SYNC_IF_EVEN) & ~i_bit0)
		| ((i_opt == SYNC_IF_ODD) & i_bit0);

endmodule

// ---- core/mco_handler.sv ----
`timescale 1ns/1ns
module mco_handler
	import mco_pkg::*;
(
	// Clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_reset_n,
	// Configuration register port
	input  wire logic              i_cfg_we,
	input  wire logic [CFG_W-1:0]  i_cfg_wdata,
	output logic [CFG_W-1:0]       o_cfg_rdata,
	// Shutdown scope from the first configuration register
	input  wire logic              i_shutdown_scope_select,
	// Host service-request set/clear into the status word bits
	input  wire logic              i_srq_set,
	input  wire logic              i_srq_clr,
	// Validated mode command from the protocol engine
	input  wire logic              i_req_valid,
	input  wire mco_req_t          i_req,
	// Results
	output logic                   o_busy,
	output logic                   o_tt_load,
	output logic [15:0]            o_tt_data,
	output logic                   o_status_start,
	output logic                   o_host_sync_evt,
	output logic                   o_service_request,
	output logic                   o_inactive_bus_inhibit_tx,
	output logic                   o_inactive_bus_inhibit_rx,
	output logic                   o_transmitter_shutdown_flag,
	output logic                   o_receiver_shutdown_flag
);

	logic [CFG_W-1:0] cfg_q;
	mco_state_t       state_q, state_d;
	mco_req_t         req_q;
	logic             srq_q, txi_q, rxi_q, transmitter_shutdown_flag_q, receiver_shutdown_flag_q;
	logic             tt_load_q, status_q, host_evt_q;
	logic [15:0]      tt_data_q;

	// Option fields decoded once
	wire logic       bus_select_handling_option = cfg_q[BIT_BUS_SEL];
	wire logic [1:0] sync_load_option_pair = {cfg_q[BIT_SYNC_HI], cfg_q[BIT_SYNC_LO]};
	wire logic       vector_word_option = cfg_q[BIT_VEC_OPT];
	wire logic       sync_ok;

	mco_sync_decide u_sync
	(
		.i_opt  (sync_load_option_pair),
		.i_bit0 (req_q.data[0]),
		.o_load (sync_ok)
	);

	// Action terms valid while in the act state
	wire logic in_act    = (state_q == MCO_ACT);
	wire logic do_load   = in_act & (req_q.cmd == MCO_CMD_SYNC) & sync_ok;
	wire logic do_host   = in_act & (req_q.cmd == MCO_CMD_SYNC)
		& (sync_load_option_pair == SYNC_HOST);
	wire logic do_srq    = in_act & (req_q.cmd == MCO_CMD_VECTOR) & ~vector_word_option;
	wire logic is_sd     = (req_q.cmd == MCO_CMD_SHUTDOWN) | (req_q.cmd == MCO_CMD_OVERRIDE);
	// Bus-select set blocks shutdown effects regardless of match
	wire logic do_sd     = in_act & is_sd & ~bus_select_handling_option & req_q.bus_match;
	wire logic sd_val    = (req_q.cmd == MCO_CMD_SHUTDOWN);
	wire logic want_sts  = in_act & ~req_q.broadcast;

	// Three-state handler: act one cycle, then status strobe
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			MCO_IDLE:   if (i_req_valid) state_d = MCO_ACT;
			MCO_ACT:    state_d = MCO_STATUS;
			MCO_STATUS: state_d = MCO_IDLE;
			default:    state_d = MCO_IDLE;
		endcase
	end

	// Configuration and state
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			cfg_q   <= CFG_RESET;
			state_q <= MCO_IDLE;
			req_q   <= '0;
		end
		else
		begin
			if (i_cfg_we)
				cfg_q <= i_cfg_wdata;
			state_q <= state_d;
			if (state_q == MCO_IDLE && i_req_valid)
				req_q <= i_req;
		end
	end

	// Service request: automatic clear beats host set, status sent next cycle
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			srq_q <= 1'b0;
		else if (do_srq)
			srq_q <= 1'b0;
		else if (i_srq_set)
			srq_q <= 1'b1;
		else if (i_srq_clr)
			srq_q <= 1'b0;
	end

	// Inactive bus inhibit and shutdown flags; scope bit limits to transmitter
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			txi_q  <= 1'b0;
			rxi_q  <= 1'b0;
			transmitter_shutdown_flag_q <= 1'b0;
			receiver_shutdown_flag_q <= 1'b0;
		end
		else if (do_sd)
		begin
			txi_q  <= sd_val;
			transmitter_shutdown_flag_q <= sd_val;
			if (!i_shutdown_scope_select)
			begin
				rxi_q  <= sd_val;
				receiver_shutdown_flag_q <= sd_val;
			end
		end
	end

	// Strobes; load and status both land in the cycle after the act cycle
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			tt_load_q  <= 1'b0;
			tt_data_q  <= 16'h0000;
			status_q   <= 1'b0;
			host_evt_q <= 1'b0;
		end
		else
		begin
			tt_load_q  <= do_load;
			if (do_load)
				tt_data_q <= req_q.data;
			status_q   <= want_sts;
			host_evt_q <= do_host;
		end
	end

	assign o_cfg_rdata                 = cfg_q;
	assign o_busy                      = (state_q != MCO_IDLE);
	assign o_tt_load                   = tt_load_q;
	assign o_tt_data                   = tt_data_q;
	assign o_status_start              = status_q;
	assign o_host_sync_evt             = host_evt_q;
	assign o_service_request           = srq_q;
	assign o_inactive_bus_inhibit_tx   = txi_q;
	assign o_inactive_bus_inhibit_rx   = rxi_q;
	assign o_transmitter_shutdown_flag = transmitter_shutdown_flag_q;
	assign o_receiver_shutdown_flag    = receiver_shutdown_flag_q;

	// Assertions
	sequence s_sync_in;
		state_q == MCO_ACT && req_q.cmd == MCO_CMD_SYNC;
	endsequence
	// Shutdown or override sitting in the act cycle
	sequence s_sd_in;
		state_q == MCO_ACT && is_sd;
	endsequence

	a_load_always: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_sync_in and sync_load_option_pair == SYNC_ALWAYS |=> o_tt_load)
		else $error("sync load missing");
	a_no_host_load: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_sync_in and sync_load_option_pair == SYNC_HOST |=> !o_tt_load && o_host_sync_evt)
		else $error("load with host option");
	a_even_load: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_sync_in and sync_load_option_pair == SYNC_IF_EVEN |=> o_tt_load == !$past(req_q.data[0]))
		else $error("even load wrong");
	a_odd_load: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_sync_in and sync_load_option_pair == SYNC_IF_ODD |=> o_tt_load == $past(req_q.data[0]))
		else $error("odd load wrong");
	a_status_sent: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		state_q == MCO_ACT && !req_q.broadcast |=> o_status_start)
		else $error("status missing");
	a_load_before_sts: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_sync_in and sync_ok && !req_q.broadcast
		|=> o_tt_load && o_status_start && o_tt_data == $past(req_q.data))
		else $error("load not ready at status start");
	a_srq_cleared: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		state_q == MCO_ACT && req_q.cmd == MCO_CMD_VECTOR && !vector_word_option
		|=> !o_service_request && o_status_start == !$past(req_q.broadcast))
		else $error("srq not cleared");
	a_sd_frozen: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		state_q == MCO_ACT && is_sd && bus_select_handling_option
		|=> $stable(o_transmitter_shutdown_flag) && $stable(o_receiver_shutdown_flag))
		else $error("shutdown flags changed");
	a_sd_update: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_sd_in and !bus_select_handling_option && req_q.bus_match
		|=> o_transmitter_shutdown_flag == $past(req_q.cmd == MCO_CMD_SHUTDOWN)
		&& o_inactive_bus_inhibit_tx == o_transmitter_shutdown_flag)
		else $error("transmitter flag not updated");
	a_sd_scope: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_sd_in and !bus_select_handling_option && req_q.bus_match && i_shutdown_scope_select
		|=> $stable(o_receiver_shutdown_flag) && $stable(o_inactive_bus_inhibit_rx))
		else $error("receiver side changed under scope");
	a_sd_no_match: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_sd_in and !req_q.bus_match
		|=> $stable(o_transmitter_shutdown_flag) && $stable(o_receiver_shutdown_flag))
		else $error("flags changed without match");
	a_srq_host_owned: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		state_q == MCO_ACT && req_q.cmd == MCO_CMD_VECTOR && vector_word_option
		&& !i_srq_set && !i_srq_clr |=> $stable(o_service_request))
		else $error("service request touched by handler");

endmodule

// ---- bench/mco_bc_model.sv ----
`timescale 1ns/1ns
// Bus controller side: sends one validated mode command at a time
module mco_bc_model
	import mco_pkg::*;
(
	// Clock
	input  wire logic i_sys_clk,
	// Command toward the handler
	output logic      o_req_valid,
	output mco_req_t  o_req
);
	// Idle until the first command
	initial
	begin
		o_req_valid = 1'b0;
		o_req       = '0;
	end
	// One-cycle pulse; data inverted after release so stale data is never mistaken
	task automatic issue(input mco_cmd_t cmd, input logic bc, input logic [15:0] data,
		input logic match);
		@(negedge i_sys_clk);
		o_req_valid = 1'b1;
		o_req       = '{cmd, bc, data, match};
		@(negedge i_sys_clk);
		o_req_valid = 1'b0;
		o_req.data  = ~data;
	endtask
endmodule

// ---- bench/mco_handler_tb.sv ----
`timescale 1ns/1ns
module mco_handler_tb;
	import mco_pkg::*;
	logic             i_sys_clk = 1'b0;
	logic             i_reset_n = 1'b0;
	logic             i_cfg_we  = 1'b0;
	logic [15:0]      i_cfg_wdata = 16'h0000;
	logic             i_scope   = 1'b0;
	logic             i_srq_set = 1'b0;
	logic             i_srq_clr = 1'b0;
	logic             req_valid;
	mco_req_t         req;
	logic [15:0]      cfg_rdata;
	logic [15:0]      tt_data;
	logic             busy, tt_load, sts, hsync, srq, itx, irx, transmitter_shutdown_flag, receiver_shutdown_flag;
	int               n_mismatch = 0;
	int               n_checks   = 0;
	logic             ld;
	// 100 MHz clock
	always #5 i_sys_clk = ~i_sys_clk;
	mco_bc_model mco_bc_model_inst (.i_sys_clk(i_sys_clk), .o_req_valid(req_valid), .o_req(req));
	mco_handler mco_handler_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
		.i_cfg_we(i_cfg_we), .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(cfg_rdata),
		.i_shutdown_scope_select(i_scope), .i_srq_set(i_srq_set), .i_srq_clr(i_srq_clr),
		.i_req_valid(req_valid), .i_req(req), .o_busy(busy), .o_tt_load(tt_load),
		.o_tt_data(tt_data), .o_status_start(sts), .o_host_sync_evt(hsync),
		.o_service_request(srq), .o_inactive_bus_inhibit_tx(itx),
		.o_inactive_bus_inhibit_rx(irx), .o_transmitter_shutdown_flag(transmitter_shutdown_flag),
		.o_receiver_shutdown_flag(receiver_shutdown_flag));
	// Single comparison point
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Config write is a one-cycle strobe
	task automatic cfg_write(input logic [15:0] v);
		@(negedge i_sys_clk);
		i_cfg_we    = 1'b1;
		i_cfg_wdata = v;
		@(negedge i_sys_clk);
		i_cfg_we    = 1'b0;
		chk(cfg_rdata, v);
	endtask
	// Host service-request set or clear
	task automatic host_srq(input logic set);
		@(negedge i_sys_clk);
		i_srq_set = set;
		i_srq_clr = !set;
		@(negedge i_sys_clk);
		i_srq_set = 1'b0;
		i_srq_clr = 1'b0;
	endtask
	// Answer stands for one cycle after the edge following take; then idle again
	task automatic run(input mco_cmd_t c, input logic bc, input logic [15:0] d,
		input logic m, input logic [7:0] e);
		mco_bc_model_inst.issue(c, bc, d, m);
		@(negedge i_sys_clk);
		chk({7'h00, busy, tt_load, sts, hsync, srq, itx, irx, transmitter_shutdown_flag, receiver_shutdown_flag}, {7'h00, 1'b1, e});
		if (e[7])
			chk(tt_data, d);
		@(negedge i_sys_clk);
		chk({14'h0000, busy, tt_load | sts | hsync}, 16'h0000);
	endtask
	// Watchdog, far beyond the roughly 130 cycles the tests need
	initial
	begin
		#100000;
		n_mismatch++;
		end_of_test();
	end
	initial
	begin
		repeat (16) @(negedge i_sys_clk);
		i_reset_n = 1'b1;
		chk(cfg_rdata, CFG_RESET);
		// Every sync option against both parities of bit 0
		for (int o = 0; o < 4; o++)
			for (int b = 0; b < 2; b++)
			begin
				cfg_write(16'(o) << BIT_SYNC_LO);
				ld = (o == 3) || (o == 1 && b == 0) || (o == 2 && b == 1);
				run(MCO_CMD_SYNC, 1'b0, 16'h5a5a | 16'(b), 1'b0, {ld, 1'b1, o == 0, 5'h00});
			end
		$display("sync option test done");
		// Vector word with automatic and host-owned clear
		cfg_write(16'h0000);
		host_srq(1'b1);
		run(MCO_CMD_VECTOR, 1'b0, 16'h0000, 1'b0, 8'h40);
		cfg_write(16'h0001 << BIT_VEC_OPT);
		host_srq(1'b1);
		run(MCO_CMD_VECTOR, 1'b0, 16'h0000, 1'b0, 8'h50);
		host_srq(1'b0);
		chk({15'h0000, srq}, 16'h0000);
		$display("vector word test done");
		// Shutdown and override, full and transmitter-only scope
		cfg_write(16'h0000);
		run(MCO_CMD_SHUTDOWN, 1'b0, 16'h0000, 1'b1, 8'h4f);
		run(MCO_CMD_OVERRIDE, 1'b0, 16'h0000, 1'b1, 8'h40);
		i_scope = 1'b1;
		run(MCO_CMD_SHUTDOWN, 1'b0, 16'h0000, 1'b1, 8'h4a);
		run(MCO_CMD_OVERRIDE, 1'b0, 16'h0000, 1'b1, 8'h40);
		i_scope = 1'b0;
		run(MCO_CMD_SHUTDOWN, 1'b0, 16'h0000, 1'b0, 8'h40);
		// Bus-select option set: nothing changes, broadcast sends no status
		cfg_write(16'h0001 << BIT_BUS_SEL);
		run(MCO_CMD_SHUTDOWN, 1'b0, 16'h0000, 1'b1, 8'h40);
		run(MCO_CMD_SHUTDOWN, 1'b1, 16'h0000, 1'b0, 8'h00);
		// Flags set first, so a wrongly honoured override would show
		cfg_write(16'h0000);
		run(MCO_CMD_SHUTDOWN, 1'b0, 16'h0000, 1'b1, 8'h4f);
		cfg_write(16'h0001 << BIT_BUS_SEL);
		run(MCO_CMD_OVERRIDE, 1'b0, 16'h0000, 1'b1, 8'h4f);
		run(MCO_CMD_OVERRIDE, 1'b1, 16'h0000, 1'b1, 8'h0f);
		$display("shutdown test done");
		// Reset in mid-run clears flags and configuration
		@(negedge i_sys_clk);
		i_reset_n = 1'b0;
		@(negedge i_sys_clk);
		i_reset_n = 1'b1;
		chk(cfg_rdata, CFG_RESET);
		chk({8'h00, tt_load, sts, hsync, srq, itx, irx, transmitter_shutdown_flag, receiver_shutdown_flag}, 16'h0000);
		$display("reset test done");
		end_of_test();
	end
endmodule
